// [pkg/cps_pkg.sv]
// Package: constants and carrier types of the charger power-up and mode sequencer
package cps_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int GOOD_DELAY_MS = 50;
  localparam int CONV_DELAY_MS = 150;
  localparam int REV_DELAY_MS = 10;
  localparam int GOOD_DELAY_CYC = GOOD_DELAY_MS * CLK_KHZ;
  localparam int CONV_DELAY_CYC = CONV_DELAY_MS * CLK_KHZ;
  localparam int REV_DELAY_CYC = REV_DELAY_MS * CLK_KHZ;
  localparam int PFM_MIN_KHZ = 25;
  localparam int PFM_PERIOD_CYC = CLK_KHZ / PFM_MIN_KHZ; // Longest gap, rounded down
  localparam int PFM_PULSE_CYC = 8;
  localparam int DEAD_NS = 20;
  localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OPT0 = 8'h00;
  localparam logic [7:0] OFS_OPT3 = 8'h04;
  localparam logic [7:0] OFS_ILIM = 8'h08;
  localparam logic [7:0] OFS_VFLOOR = 8'h0c;
  localparam logic [7:0] OFS_CHGV = 8'h10;
  localparam logic [7:0] OFS_REVV = 8'h14;
  localparam logic [7:0] OFS_REVI = 8'h18;
  localparam logic [7:0] OFS_SYSTEM_OVERVOLTAGE_THRESHOLD = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_EFFILIM = 8'h24;
  localparam int OPT0_LOW_POWER = 15;
  localparam int OPT0_REV_GOOD = 11;
  localparam int OPT0_PFM_MIN = 10;
  localparam int OPT3_HIZ = 15;
  localparam int OPT3_REV_EN = 12;
  localparam logic [15:0] OPT0_RST = 16'h8000;
  localparam logic [15:0] OPT3_RST = 16'h0000;
  // Currents in mA, voltages in mV
  localparam logic [15:0] ILIM_DEFAULT = 16'h0ce4;
  localparam logic [15:0] VFLOOR_OFFSET = 16'h0500;
  localparam logic [15:0] CHGV_4S = 16'h41a0;
  localparam logic [15:0] CHGV_3S = 16'h3130;
  localparam logic [15:0] CHGV_2S = 16'h20d0;
  localparam logic [15:0] CHGV_1S = 16'h1060;
  localparam logic [15:0] SYSTEM_OVERVOLTAGE_THRESHOLD_HI = 16'h4c2c;
  localparam logic [15:0] SYSTEM_OVERVOLTAGE_THRESHOLD_2S = 16'h2ee0;
  localparam logic [15:0] SYSTEM_OVERVOLTAGE_THRESHOLD_1S = 16'h1388;
  // Cell pin ratio in percent of the regulator; lowest accepted level
  localparam logic [6:0] CELL4_MIN = 7'h45;
  localparam logic [6:0] CELL3_MIN = 7'h34;
  localparam logic [6:0] CELL2_MIN = 7'h23;
  localparam logic [6:0] CELL1_MIN = 7'h13;
  // Inductor resistor in kOhm; split points between 93, 137 and 169
  localparam logic [7:0] IND_SPLIT_LO = 8'h73;
  localparam logic [7:0] IND_SPLIT_HI = 8'h99;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_WAIT = 4'h0, ST_DEGLITCH = 4'h1, ST_LIMITS = 4'h2, ST_CELL = 4'h3,
    ST_HOLD = 4'h4, ST_RUN = 4'h5, ST_REV_WAIT = 4'h6, ST_REV_RUN = 4'h7
  } cps_state_t;
  typedef enum logic [1:0] {LEG_OFF = 2'h0, LEG_ON = 2'h1, LEG_SW = 2'h2} cps_leg_t;
  typedef enum logic [1:0] {CONV_BUCK = 2'h0, CONV_BOOST = 2'h1, CONV_BB = 2'h2} cps_conv_t;
  typedef enum logic [1:0] {IND_1U0 = 2'h0, IND_2U2 = 2'h1, IND_3U3 = 2'h2} cps_ind_t;
  typedef struct packed {
    logic cyc; logic stb; logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;
  } cps_wb_req_t;
  typedef struct packed {logic ack; logic [31:0] dat;} cps_wb_rsp_t;
  typedef struct packed {
    logic vbusConven; logic vbusOv; logic vbusUvlo; logic vbatUvloz; logic fault;
    logic inputLimitPinLow; logic analogSupplyReady; logic reverseOutputEnablePin;
    logic lightLoad; logic pfmReq; logic pwmBuck; logic pwmBoost; logic [1:0] convMode;
  } cps_sense_t;
  typedef struct packed {
    logic [6:0] cellCountSensePin; logic [7:0] inputCurrentMonitorPin;
    logic [15:0] inputLimitPinMa; logic [15:0] vbusNoLoad;
  } cps_meas_t;
  typedef struct packed {logic q1; logic q2; logic q3; logic q4;} cps_sw_t;
endpackage

// [testbench/cps_host_model.sv]
// Host controller model: classic Wishbone master cycles
`timescale 1ns/1ps
module cps_host_model (
  input wire logic core_clk,
  output cps_pkg::cps_wb_req_t wbReq,
  input wire cps_pkg::cps_wb_rsp_t wbRsp
);
  int timeouts = 0;
  initial wbReq = '0;
  // Request held until ack is sampled; released lines show inverted leftovers
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wbReq <= '{1'b1, 1'b1, we, a, 4'h3, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wbRsp.ack !== 1'b1 && n < 20);
    if (n >= 20)
      timeouts++;
    q = wbRsp.dat;
    wbReq <= '{1'b0, 1'b0, 1'b0, ~a, 4'h0, ~d};
  endtask
endmodule

// [testbench/cps_sequencer_tb_top.sv]
// Register-level testbench for the power-up and mode sequencer
`timescale 1ns/1ps
module cps_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  cps_pkg::cps_wb_req_t wbReq;
  cps_pkg::cps_wb_rsp_t wbRsp;
  cps_pkg::cps_sense_t sense = '0;
  cps_pkg::cps_meas_t meas = '0;
  cps_pkg::cps_sw_t sw;
  logic sgOut, sgOe, bpath, gdrv;
  logic [31:0] q;
  int errors = 0;
  int n_compared = 0;
  int i;
  // Open-drain pad with pull-up
  wire logic pad = sgOe ? sgOut : 1'b1;
  always #2.5 core_clk = ~core_clk;
  cps_host_model cps_host_model_inst (.core_clk(core_clk), .wbReq(wbReq), .wbRsp(wbRsp));
  // Short delays keep the run brief; expectations follow these values
  cps_sequencer #(.GOOD_CYC(40), .CONV_CYC(120), .REV_CYC(20), .PFM_CYC(50)) cps_sequencer_inst (
    .core_clk(core_clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .sensePins(sense),
    .measPins(meas), .supplyGoodIndicatorIn(pad), .supplyGoodIndicatorOut(sgOut),
    .supplyGoodIndicatorOe(sgOe), .batteryPathSwitch(bpath), .gateDriveRegulatorEn(gdrv),
    .switches(sw));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cps_host_model_inst.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), exp, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cps_host_model_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic st(input logic [3:0] e);
    cps_host_model_inst.xfer(1'b0, cps_pkg::OFS_STATUS, 32'h0, q);
    chk("state", e, q[13:10]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic finish_test;
    chk("timeouts", 0, cps_host_model_inst.timeouts);
    $display("Compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    sense.convMode <= 2'h3;
    tick(3);
    rst <= 1'b0;
    rd(cps_pkg::OFS_OPT0, 32'h8000);
    chk("gdrv", 0, gdrv);
    rd(8'h30, 32'h0);
    sense.vbatUvloz <= 1'b1;
    tick(6);
    chk("bpath", 1, bpath);
    wr(cps_pkg::OFS_OPT0, 32'h0);
    tick(2);
    chk("gdrv", 1, gdrv);
    wr(cps_pkg::OFS_OPT0, 32'h8000);
    tick(2);
    chk("gdrv", 0, gdrv);
    sense.vbusConven <= 1'b1;
    tick(20);
    sense.vbusConven <= 1'b0;
    tick(5);
    st(4'h0);
    chk("oe", 1, sgOe);
    $display("Test reset done");
    meas <= '{7'h4b, 8'h89, 16'h07d0, 16'h4e20};
    sense.analogSupplyReady <= 1'b1;
    sense.vbusConven <= 1'b1;
    tick(30);
    chk("oe early", 1, sgOe);
    for (i = 0; i < 40 && sgOe !== 1'b0; i++)
      tick(1);
    chk("oe", 0, sgOe);
    chk("gdrv", 1, gdrv);
    rd(cps_pkg::OFS_ILIM, 32'h0ce4);
    rd(cps_pkg::OFS_EFFILIM, 32'h07d0);
    rd(cps_pkg::OFS_VFLOOR, 32'h4920);
    rd(cps_pkg::OFS_CHGV, 32'h41a0);
    rd(cps_pkg::OFS_SYSTEM_OVERVOLTAGE_THRESHOLD, 32'h4c2c);
    wr(cps_pkg::OFS_ILIM, 32'h05dc);
    rd(cps_pkg::OFS_ILIM, 32'h05dc);
    rd(cps_pkg::OFS_EFFILIM, 32'h05dc);
    st(4'h4);
    chk("inductor", 1, q[9:8]);
    chk("cells", 4, q[7:5]);
    tick(80);
    st(4'h5);
    // Buck, boost, buck-boost legs after dead time settles
    for (i = 0; i < 3; i++)
    begin
      sense.convMode <= i[1:0];
      {sense.pwmBuck, sense.pwmBoost} <= (i == 2) ? 2'b11 : 2'b00;
      tick(12);
      chk("switches", (i == 0) ? 4'h5 : (i == 1) ? 4'ha : 4'h9, sw);
    end
    sense.fault <= 1'b1;
    tick(5);
    chk("oe fault", 1, sgOe);
    wr(cps_pkg::OFS_OPT3, 32'h8000);
    st(4'h5);
    chk("hiz bit", 1, q[2]);
    chk("gdrv", 1, gdrv);
    wr(cps_pkg::OFS_OPT3, 32'h0);
    sense.inputLimitPinLow <= 1'b1;
    tick(5);
    st(4'h5);
    chk("hiz pin", 1, q[2]);
    $display("Test power-up done");
    {sense.vbusConven, sense.vbusUvlo, sense.fault, sense.reverseOutputEnablePin} <= 4'h5;
    wr(cps_pkg::OFS_CHGV, 32'h1060);
    wr(cps_pkg::OFS_REVV, 32'h1388);
    wr(cps_pkg::OFS_REVI, 32'h0400);
    wr(cps_pkg::OFS_OPT0, 32'h8800);
    st(4'h0);
    wr(cps_pkg::OFS_OPT3, 32'h1000);
    tick(8);
    st(4'h6);
    tick(20);
    st(4'h7);
    chk("oe rev", 0, sgOe);
    $display("Test reverse done");
    // Light load with the frequency floor: demand drops, then a forced pulse must come
    wr(cps_pkg::OFS_OPT0, 32'h8c00);
    sense.lightLoad <= 1'b1;
    for (i = 0; i < 30 && sw.q1 !== 1'b0; i++)
      tick(1);
    chk("pfm gap", 0, sw.q1);
    for (i = 0; i < 80 && sw.q1 !== 1'b1; i++)
      tick(1);
    chk("pfm pulse", 1, sw.q1);
    $display("Test light load done");
    finish_test();
  end
endmodule

// [verilog/cps_leg.sv]
// One half-bridge leg with break-before-make dead time
`timescale 1ns/1ps
module cps_leg #(
  parameter int DEAD = cps_pkg::DEAD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire cps_pkg::cps_leg_t legMode,
  input wire logic demand,
  output logic highSide,
  output logic lowSide
);
  localparam int DW = $clog2(DEAD + 1);
  typedef struct packed {logic hs; logic ls; logic [DW-1:0] dead;} cps_leg_st_t;
  cps_leg_st_t s;
  cps_leg_st_t next_s;
  logic wantHigh;
  logic wantLow;

  // Wanted switch from mode and demand
  assign wantHigh = legMode == cps_pkg::LEG_ON || (legMode == cps_pkg::LEG_SW && demand);
  assign wantLow = legMode == cps_pkg::LEG_SW && !demand;

  // Turn off first, wait out the dead time, then turn the other on
  always_comb
  begin
    next_s = s;
    if ((s.hs && !wantHigh) || (s.ls && !wantLow))
    begin
      next_s.hs = s.hs && wantHigh;
      next_s.ls = s.ls && wantLow;
      next_s.dead = DW'(DEAD);
    end
    else if (s.dead != '0)
      next_s.dead = s.dead - DW'(1);
    else if (wantHigh && !s.ls)
      next_s.hs = 1'b1;
    else if (wantLow && !s.hs)
      next_s.ls = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign highSide = s.hs;
  assign lowSide = s.ls;

  property p_no_overlap;
    @(posedge core_clk) disable iff (rst) !(s.hs && s.ls);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches of a leg on");
  property p_dead_gap;
    @(posedge core_clk) disable iff (rst) $fell(s.hs) |-> !s.ls [*4];
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("low side on inside dead time");
endmodule

// [verilog/cps_sequencer.sv]
// Power-up, high-impedance, reverse output and switch-mode sequencer with Wishbone registers
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - No input and battery above release level: close the battery path switch.
// - After reset: low power bit reads one, gate drive regulator off.
// - Low power bit cleared: gate drive regulator turns on.
// - 50 ms after input crosses threshold: regulator on, supply-good asserts.
// - Then limits, then cell count; converter starts 150 ms after crossing.
// - Supply-good only with input in window and no fault.
// - Supply-good rising loads input current limit with 3.30 A.
// - Effective current limit is the smaller of register and pin limit.
// - Input voltage floor defaults to unloaded input minus 1.28 V.
// - After analog supply ready, decode cell pin into charge voltage and overvoltage.
// - High-impedance when limit pin below 0.4 V or its bit is one.
// - High-impedance with input: low quiescent, gate drive regulator stays on.
// - Reverse output needs programmed values, pin, bit and input below undervoltage.
// - Reverse conditions held 10 ms: start converter.
// - In reverse output, supply-good follows its option bit.
// - Switch states per mode: buck, boost, buck-boost.
// - Inductor value decoded from monitor pin resistor.
// - High and low switches never on together; dead time between.
// - Light load uses pulse mode; frequency kept at or above 25 kHz if enabled.
module cps_sequencer #(
  parameter int GOOD_CYC = cps_pkg::GOOD_DELAY_CYC,
  parameter int CONV_CYC = cps_pkg::CONV_DELAY_CYC,
  parameter int REV_CYC = cps_pkg::REV_DELAY_CYC,
  parameter int PFM_CYC = cps_pkg::PFM_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire cps_pkg::cps_wb_req_t wbReq,
  output cps_pkg::cps_wb_rsp_t wbRsp,
  input wire cps_pkg::cps_sense_t sensePins,
  input wire cps_pkg::cps_meas_t measPins,
  input wire logic supplyGoodIndicatorIn,
  output logic supplyGoodIndicatorOut,
  output logic supplyGoodIndicatorOe,
  output logic batteryPathSwitch,
  output logic gateDriveRegulatorEn,
  output cps_pkg::cps_sw_t switches
);
  localparam int TW = $clog2(CONV_CYC + 1);
  localparam int PW = $clog2(PFM_CYC + 1);
  typedef struct packed {
    cps_pkg::cps_state_t state;
    logic [TW-1:0] timer;
    logic [15:0] opt0;
    logic [15:0] opt3;
    logic [15:0] ilim;
    logic [15:0] vfloor;
    logic [15:0] chgv;
    logic [15:0] revv;
    logic [15:0] revi;
    logic [15:0] system_overvoltage_threshold;
    logic [2:0] cells;
    cps_pkg::cps_ind_t ind;
    logic good;
    logic gdrv;
    logic bpath;
    logic [PW-1:0] pfmGap;
    logic [3:0] pfmPulse;
    logic ack;
    logic [31:0] rdat;
  } cps_seq_st_t;

  cps_seq_st_t s;
  cps_seq_st_t next_s;
  cps_pkg::cps_sense_t sv;
  cps_pkg::cps_meas_t mv;
  logic padIn;
  logic hiZ;
  logic revOk;
  logic fwdOk;
  logic running;
  logic pfmWindow;
  logic busReq;
  logic [15:0] effIlim;
  logic [15:0] rmux;
  cps_pkg::cps_leg_t buckMode;
  cps_pkg::cps_leg_t boostMode;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  cps_sync #(.W($bits(cps_pkg::cps_sense_t))) u_sync_sense (
    .core_clk(core_clk),
    .rst(rst),
    .din(sensePins),
    .dout(sv)
  );
  // Measurements are slow analog codes, so a plain two-flop pass is enough
  cps_sync #(.W($bits(cps_pkg::cps_meas_t))) u_sync_meas (
    .core_clk(core_clk),
    .rst(rst),
    .din(measPins),
    .dout(mv)
  );
  cps_sync #(.W(1)) u_sync_pad (
    .core_clk(core_clk),
    .rst(rst),
    .din(supplyGoodIndicatorIn),
    .dout(padIn)
  );

  // ---------------------------------------------------------------
  // Derived conditions
  // ---------------------------------------------------------------
  assign hiZ = sv.inputLimitPinLow || s.opt3[cps_pkg::OPT3_HIZ];
  assign fwdOk = sv.vbusConven && !sv.vbusOv && !sv.fault;
  // Every enable term must hold at once
  assign revOk = s.chgv != '0 && s.revv != '0 && s.revi != '0 && sv.reverseOutputEnablePin
    && s.opt3[cps_pkg::OPT3_REV_EN] && sv.vbusUvlo;
  // High-impedance stops switching only in the forward run, not in reverse; the regulator stays up
  assign running = (s.state == cps_pkg::ST_RUN && !hiZ) || s.state == cps_pkg::ST_REV_RUN;
  assign effIlim = (s.ilim < mv.inputLimitPinMa) ? s.ilim : mv.inputLimitPinMa;
  assign pfmWindow = sv.pfmReq || s.pfmPulse != '0;
  assign busReq = wbReq.cyc && wbReq.stb && !s.ack;

  // Register read multiplexer
  always_comb
  begin
    case (wbReq.adr & 8'hfc)
      cps_pkg::OFS_OPT0: rmux = s.opt0;
      cps_pkg::OFS_OPT3: rmux = s.opt3;
      cps_pkg::OFS_ILIM: rmux = s.ilim;
      cps_pkg::OFS_VFLOOR: rmux = s.vfloor;
      cps_pkg::OFS_CHGV: rmux = s.chgv;
      cps_pkg::OFS_REVV: rmux = s.revv;
      cps_pkg::OFS_REVI: rmux = s.revi;
      cps_pkg::OFS_SYSTEM_OVERVOLTAGE_THRESHOLD: rmux = s.system_overvoltage_threshold;
      cps_pkg::OFS_STATUS: rmux = {2'h0, s.state, s.ind, s.cells, s.gdrv, s.bpath, hiZ, padIn, s.good};
      cps_pkg::OFS_EFFILIM: rmux = effIlim;
      default: rmux = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer, registers and bus
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.ack = busReq;
    if (busReq && !wbReq.we)
      next_s.rdat = {16'h0000, rmux};
    // Host writes come first so a same-cycle device load wins
    if (busReq && wbReq.we)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (wbReq.sel[b])
        begin
          case (wbReq.adr & 8'hfc)
            cps_pkg::OFS_OPT0: next_s.opt0[b*8 +: 8] = wbReq.dat[b*8 +: 8];
            cps_pkg::OFS_OPT3: next_s.opt3[b*8 +: 8] = wbReq.dat[b*8 +: 8];
            cps_pkg::OFS_ILIM: next_s.ilim[b*8 +: 8] = wbReq.dat[b*8 +: 8];
            cps_pkg::OFS_VFLOOR: next_s.vfloor[b*8 +: 8] = wbReq.dat[b*8 +: 8];
            cps_pkg::OFS_CHGV: next_s.chgv[b*8 +: 8] = wbReq.dat[b*8 +: 8];
            cps_pkg::OFS_REVV: next_s.revv[b*8 +: 8] = wbReq.dat[b*8 +: 8];
            cps_pkg::OFS_REVI: next_s.revi[b*8 +: 8] = wbReq.dat[b*8 +: 8];
            default: next_s.opt0 = next_s.opt0;
          endcase
        end
      end
    end
    // Timer runs from the threshold crossing through the waiting states
    if (s.state != cps_pkg::ST_WAIT && s.state != cps_pkg::ST_RUN && s.state != cps_pkg::ST_REV_RUN)
      next_s.timer = s.timer + TW'(1);
    case (s.state)
      cps_pkg::ST_WAIT:
      begin
        next_s.timer = '0;
        if (sv.vbusConven)
          next_s.state = cps_pkg::ST_DEGLITCH;
        else if (revOk)
          next_s.state = cps_pkg::ST_REV_WAIT;
      end
      cps_pkg::ST_DEGLITCH:
      begin
        if (s.timer == TW'(GOOD_CYC - 1))
          next_s.state = cps_pkg::ST_LIMITS;
      end
      cps_pkg::ST_LIMITS:
      begin
        next_s.ilim = cps_pkg::ILIM_DEFAULT;
        // Saturate so a weak source never wraps the floor
        next_s.vfloor = (mv.vbusNoLoad > cps_pkg::VFLOOR_OFFSET)
          ? mv.vbusNoLoad - cps_pkg::VFLOOR_OFFSET : 16'h0000;
        next_s.state = cps_pkg::ST_CELL;
      end
      cps_pkg::ST_CELL:
      begin
        if (sv.analogSupplyReady)
        begin
          next_s.state = cps_pkg::ST_HOLD;
          // Below the 1-cell level the battery is absent and defaults stay
          if (mv.cellCountSensePin >= cps_pkg::CELL4_MIN)
          begin
            next_s.cells = 3'h4;
            next_s.chgv = cps_pkg::CHGV_4S;
            next_s.system_overvoltage_threshold = cps_pkg::SYSTEM_OVERVOLTAGE_THRESHOLD_HI;
          end
          else if (mv.cellCountSensePin >= cps_pkg::CELL3_MIN)
          begin
            next_s.cells = 3'h3;
            next_s.chgv = cps_pkg::CHGV_3S;
            next_s.system_overvoltage_threshold = cps_pkg::SYSTEM_OVERVOLTAGE_THRESHOLD_HI;
          end
          else if (mv.cellCountSensePin >= cps_pkg::CELL2_MIN)
          begin
            next_s.cells = 3'h2;
            next_s.chgv = cps_pkg::CHGV_2S;
            next_s.system_overvoltage_threshold = cps_pkg::SYSTEM_OVERVOLTAGE_THRESHOLD_2S;
          end
          else if (mv.cellCountSensePin >= cps_pkg::CELL1_MIN)
          begin
            next_s.cells = 3'h1;
            next_s.chgv = cps_pkg::CHGV_1S;
            next_s.system_overvoltage_threshold = cps_pkg::SYSTEM_OVERVOLTAGE_THRESHOLD_1S;
          end
          // Inductor sense shares the regulator bring-up
          if (mv.inputCurrentMonitorPin < cps_pkg::IND_SPLIT_LO)
            next_s.ind = cps_pkg::IND_1U0;
          else if (mv.inputCurrentMonitorPin < cps_pkg::IND_SPLIT_HI)
            next_s.ind = cps_pkg::IND_2U2;
          else
            next_s.ind = cps_pkg::IND_3U3;
        end
      end
      cps_pkg::ST_HOLD:
      begin
        if (s.timer >= TW'(CONV_CYC - 1))
          next_s.state = cps_pkg::ST_RUN;
      end
      cps_pkg::ST_RUN: next_s.state = cps_pkg::ST_RUN;
      cps_pkg::ST_REV_WAIT:
      begin
        if (!revOk)
          next_s.state = cps_pkg::ST_WAIT;
        else if (s.timer == TW'(REV_CYC - 1))
          next_s.state = cps_pkg::ST_REV_RUN;
      end
      cps_pkg::ST_REV_RUN:
      begin
        if (!revOk)
          next_s.state = cps_pkg::ST_WAIT;
      end
      default: next_s.state = cps_pkg::ST_WAIT;
    endcase
    // Losing the input anywhere on the forward path restarts the sequence
    if (!sv.vbusConven && s.state >= cps_pkg::ST_DEGLITCH && s.state <= cps_pkg::ST_RUN)
      next_s.state = cps_pkg::ST_WAIT;
    // Indicator follows the forward window, or the option bit in reverse
    next_s.good = (next_s.state >= cps_pkg::ST_LIMITS && next_s.state <= cps_pkg::ST_RUN && fwdOk)
      || (next_s.state == cps_pkg::ST_REV_RUN && s.opt0[cps_pkg::OPT0_REV_GOOD]);
    next_s.gdrv = !s.opt0[cps_pkg::OPT0_LOW_POWER]
      || (next_s.state >= cps_pkg::ST_LIMITS && next_s.state <= cps_pkg::ST_REV_RUN);
    next_s.bpath = !sv.vbusConven && sv.vbatUvloz;
    // Pulse mode: force a pulse when the gap reaches the longest period
    if (pfmWindow || !running)
      next_s.pfmGap = '0;
    else
      next_s.pfmGap = s.pfmGap + PW'(1);
    if (s.pfmPulse != '0)
      next_s.pfmPulse = s.pfmPulse - 4'h1;
    else if (running && sv.lightLoad && s.opt0[cps_pkg::OPT0_PFM_MIN] && s.pfmGap >= PW'(PFM_CYC - 1))
      next_s.pfmPulse = 4'(cps_pkg::PFM_PULSE_CYC);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.opt0 <= cps_pkg::OPT0_RST;
      s.opt3 <= cps_pkg::OPT3_RST;
    end
    else
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // Converter legs
  // ---------------------------------------------------------------
  // Leg roles by converter mode
  always_comb
  begin
    buckMode = cps_pkg::LEG_OFF;
    boostMode = cps_pkg::LEG_OFF;
    if (running)
    begin
      case (cps_pkg::cps_conv_t'(sv.convMode))
        cps_pkg::CONV_BUCK:
        begin
          buckMode = cps_pkg::LEG_SW;
          boostMode = cps_pkg::LEG_ON;
        end
        cps_pkg::CONV_BOOST:
        begin
          buckMode = cps_pkg::LEG_ON;
          boostMode = cps_pkg::LEG_SW;
        end
        cps_pkg::CONV_BB:
        begin
          buckMode = cps_pkg::LEG_SW;
          boostMode = cps_pkg::LEG_SW;
        end
        default:
        begin
          buckMode = cps_pkg::LEG_OFF;
          boostMode = cps_pkg::LEG_OFF;
        end
      endcase
    end
  end

  cps_leg u_leg_buck (
    .core_clk(core_clk),
    .rst(rst),
    .legMode(buckMode),
    .demand(sv.pwmBuck && (!sv.lightLoad || pfmWindow)),
    .highSide(switches.q1),
    .lowSide(switches.q2)
  );
  cps_leg u_leg_boost (
    .core_clk(core_clk),
    .rst(rst),
    .legMode(boostMode),
    .demand(sv.pwmBoost && (!sv.lightLoad || pfmWindow)),
    .highSide(switches.q4),
    .lowSide(switches.q3)
  );

  // Open drain: pull low whenever not good
  assign supplyGoodIndicatorOut = 1'b0;
  assign supplyGoodIndicatorOe = !s.good;
  assign batteryPathSwitch = s.bpath;
  assign gateDriveRegulatorEn = s.gdrv;
  assign wbRsp.ack = s.ack;
  assign wbRsp.dat = s.rdat;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_batt_path;
    sv.vbusConven |=> !s.bpath;
  endproperty
  a_batt_path: assert property (p_batt_path) else $error("battery path closed with input");
  property p_reset_low_power;
    $fell(rst) |-> s.opt0[cps_pkg::OPT0_LOW_POWER] && !s.gdrv;
  endproperty
  a_reset_low_power: assert property (p_reset_low_power) else $error("not in low power");
  property p_perf_gdrv;
    !s.opt0[cps_pkg::OPT0_LOW_POWER] |=> s.gdrv;
  endproperty
  a_perf_gdrv: assert property (p_perf_gdrv) else $error("regulator off in performance");
  property p_good_time;
    $rose(s.state == cps_pkg::ST_LIMITS) |-> $past(s.timer) == TW'(GOOD_CYC - 1) && s.gdrv;
  endproperty
  a_good_time: assert property (p_good_time) else $error("wrong supply-good delay");
  property p_conv_time;
    $rose(s.state == cps_pkg::ST_RUN) |-> $past(s.timer) >= TW'(CONV_CYC - 1);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("converter started early");
  property p_good_window;
    s.good && s.state != cps_pkg::ST_REV_RUN |-> $past(fwdOk);
  endproperty
  a_good_window: assert property (p_good_window) else $error("supply-good outside window");
  property p_ilim_load;
    s.state == cps_pkg::ST_LIMITS |=> s.ilim == cps_pkg::ILIM_DEFAULT;
  endproperty
  a_ilim_load: assert property (p_ilim_load) else $error("limit default not loaded");
  property p_eff_ilim;
    effIlim <= s.ilim && effIlim <= mv.inputLimitPinMa;
  endproperty
  a_eff_ilim: assert property (p_eff_ilim) else $error("effective limit not the minimum");
  // Two cycles of high impedance: a leg may restart as soon as the mode is left again
  property p_hiz_off;
    hiZ && s.state == cps_pkg::ST_RUN ##1 hiZ |=> !switches.q1 && !switches.q3;
  endproperty
  a_hiz_off: assert property (p_hiz_off) else $error("switching in high impedance");
  // Same-cycle check, since an input loss may end the run right after
  property p_hiz_gdrv;
    hiZ && s.state == cps_pkg::ST_RUN |-> s.gdrv;
  endproperty
  a_hiz_gdrv: assert property (p_hiz_gdrv) else $error("regulator off in high impedance");
  property p_rev_time;
    $rose(s.state == cps_pkg::ST_REV_RUN) |-> $past(s.timer) == TW'(REV_CYC - 1);
  endproperty
  a_rev_time: assert property (p_rev_time) else $error("wrong reverse delay");
  property p_lost_input;
    !sv.vbusConven && s.state >= cps_pkg::ST_DEGLITCH && s.state <= cps_pkg::ST_RUN
      |=> s.state == cps_pkg::ST_WAIT && !s.good;
  endproperty
  a_lost_input: assert property (p_lost_input) else $error("input loss not handled");
  c_run: cover property ($rose(s.state == cps_pkg::ST_RUN));
  c_rev_run: cover property ($rose(s.state == cps_pkg::ST_REV_RUN));
  c_pfm_force: cover property ($rose(s.pfmPulse != '0));
endmodule

// [verilog/cps_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module cps_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {logic [W-1:0] meta; logic [W-1:0] held;} cps_sync_st_t;
  cps_sync_st_t s;
  cps_sync_st_t next_s;

  // First stage is read by the second stage only
  always_comb
  begin
    next_s.meta = din;
    next_s.held = s.meta;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign dout = s.held;
endmodule
